// [tb_uff_channel.sv]
// tb_uff_channel.sv: self-checking bench of one serial channel through apb
// assumes: uff_params.svh on the include path; uff_remote sits on the serial pins
`include "uff_params.svh"
module tb_uff_channel;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic        rxd, cts_n, txd, rts_n, irq, irq_s, rts_s;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  int          bad_count, checks_done;
  logic [4:0]  tl[4] = '{5'd1, 5'd4, 5'd8, 5'd14};
  logic [4:0]  rl[4] = '{5'd0, 5'd1, 5'd4, 5'd8};
  localparam int TMO = (`UFF_TMO_WORDS * 8 + `UFF_TMO_BITS) * `UFF_OVS;
  uff_channel u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rxd(rxd), .cts_n(cts_n), .txd(txd), .rts_n(rts_n), .irq(irq));
  uff_remote u_rem (.pclk(pclk), .txd(txd), .rxd(rxd), .cts_n(cts_n));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // pins sampled where settled
  always @(negedge pclk) begin
    irq_s <= irq;
    rts_s <= rts_n;
  end
  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    checks_done++;
    if (g !== x) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic chkp(input logic g, input logic x);
    chk({31'h0, g}, {31'h0, x});
  endtask
  task automatic qchk(input logic [7:0] x);
    chk({24'h0, u_rem.got_q.pop_front()}, {24'h0, x});
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    if (pready !== 1'b1) chkp(pready, 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic waitls(input logic [7:0] m);
    int n;
    n = 0;
    do begin
      apb(1'b0, `UFF_A_LSTA, 32'h0);
      n++;
    end while ((r[7:0] & m) == 8'h00 && n < 1000);
    if ((r[7:0] & m) == 8'h00) chk(r, {24'h0, m});
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge pclk);
    bad_count++;
    give_verdict();
  end
  // ==========================================================
  // tests
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`UFF_A_LSTA, 32'h60);
    rdc(`UFF_A_ISTA, 32'h01);
    for (int a = 8'h18; a <= 8'h28; a += 4) rdc(8'(a), 32'h0);
    rdc(`UFF_A_DIV, 32'h1);
    apb(1'b0, 8'h30, 32'h0);
    chkp(e, 1'b1);
    chkp(rts_s, 1'b1);
    $display("test reset done");
    wr(`UFF_A_ISTA, 32'h01);
    wr(`UFF_A_LCTL, 32'h03);
    wr(`UFF_A_IEN, 32'h02);
    rdc(`UFF_A_ISTA, 32'h02);
    chkp(irq_s, 1'b1);
    wr(`UFF_A_ENH, 32'h80);
    u_rem.set_cts(1'b1);
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 17; i++) wr(`UFF_A_DATA, 32'h40 + i);
    rdc(`UFF_A_LSTA, 32'h00);
    rdc(`UFF_A_ISTA, 32'h01);
    u_rem.set_cts(1'b0);
    waitls(8'h20);
    chk(r, 32'h20);
    waitls(8'h40);
    chk(r, 32'h60);
    chk(u_rem.got_q.size(), 32'h10);
    for (int i = 0; i < 16; i++) qchk(8'(8'h40 + i));
    wr(`UFF_A_IEN, 32'h00);
    chkp(irq_s, 1'b0);
    $display("test transmit done");
    u_rem.glitch();
    repeat (40) @(posedge pclk);
    rdc(`UFF_A_LSTA, 32'h60);
    u_rem.send(8'ha5, 1'b1);
    u_rem.send(8'h3c, 1'b0);
    u_rem.send(8'h5a, 1'b1);
    rdc(`UFF_A_LSTA, 32'h61);
    rdc(`UFF_A_DATA, 32'ha5);
    rdc(`UFF_A_LSTA, 32'h69);
    rdc(`UFF_A_DATA, 32'h3c);
    rdc(`UFF_A_LSTA, 32'h61);
    rdc(`UFF_A_DATA, 32'h5a);
    $display("test receive done");
    wr(`UFF_A_ISTA, 32'h41);
    wr(`UFF_A_IEN, 32'h01);
    for (int i = 0; i < 4; i++) begin
      rdc(`UFF_A_ISTA, 32'h01);
      u_rem.send(8'(8'h10 + i), 1'b1);
    end
    rdc(`UFF_A_ISTA, 32'h04);
    chkp(irq_s, 1'b1);
    rdc(`UFF_A_DATA, 32'h10);
    repeat (TMO - 100) @(posedge pclk);
    rdc(`UFF_A_ISTA, 32'h01);
    repeat (150) @(posedge pclk);
    rdc(`UFF_A_ISTA, 32'h08);
    for (int i = 1; i < 4; i++) rdc(`UFF_A_DATA, 32'h10 + i);
    wr(`UFF_A_IEN, 32'h00);
    $display("test trigger and timeout done");
    wr(`UFF_A_ENH, 32'h50);
    wr(`UFF_A_IEN, 32'h40);
    chkp(rts_s, 1'b1);
    wr(`UFF_A_MCTL, 32'h02);
    chkp(rts_s, 1'b0);
    for (int i = 0; i < 4; i++) u_rem.send(8'(8'h20 + i), 1'b1);
    chkp(rts_s, 1'b1);
    rdc(`UFF_A_ISTA, 32'h20);
    rdc(`UFF_A_ISTA, 32'h01);
    for (int i = 0; i < 4; i++) begin
      repeat (2) @(posedge pclk);
      chkp(rts_s, i != 3);
      rdc(`UFF_A_DATA, 32'h20 + i);
    end
    wr(`UFF_A_IEN, 32'h00);
    $display("test auto rts done");
    wr(`UFF_A_ENH, 32'h90);
    wr(`UFF_A_IEN, 32'h80);
    wr(`UFF_A_DATA, 32'h61);
    wr(`UFF_A_DATA, 32'h62);
    repeat (60) @(posedge pclk);
    u_rem.set_cts(1'b1);
    repeat (6) @(posedge pclk);
    chkp(irq_s, 1'b1);
    rdc(`UFF_A_ISTA, 32'h20);
    repeat (400) @(posedge pclk);
    chk(u_rem.got_q.size(), 32'h1);
    qchk(8'h61);
    u_rem.set_cts(1'b0);
    waitls(8'h40);
    qchk(8'h62);
    wr(`UFF_A_IEN, 32'h00);
    $display("test auto cts done");
    wr(`UFF_A_LCTL, 32'h00);
    u_rem.nbits = 5;
    wr(`UFF_A_XOFF1, 32'hf3);
    wr(`UFF_A_XON1, 32'hf1);
    wr(`UFF_A_ENH, 32'h01);
    wr(`UFF_A_IEN, 32'h20);
    u_rem.send(8'h13, 1'b1);
    chkp(irq_s, 1'b1);
    rdc(`UFF_A_LSTA, 32'h60);
    wr(`UFF_A_DATA, 32'h15);
    repeat (300) @(posedge pclk);
    chk(u_rem.got_q.size(), 32'h0);
    u_rem.send(8'h11, 1'b1);
    rdc(`UFF_A_ISTA, 32'h01);
    waitls(8'h40);
    qchk(8'h15);
    wr(`UFF_A_LCTL, 32'h03);
    u_rem.nbits = 8;
    wr(`UFF_A_IEN, 32'h00);
    $display("test xon xoff done");
    wr(`UFF_A_XOFF1, 32'h13);
    wr(`UFF_A_XOFF2, 32'h93);
    wr(`UFF_A_XON1, 32'h11);
    wr(`UFF_A_XON2, 32'h91);
    wr(`UFF_A_ENH, 32'h03);
    u_rem.send(8'h13, 1'b1);
    u_rem.send(8'h55, 1'b1);
    rdc(`UFF_A_DATA, 32'h55);
    u_rem.send(8'h13, 1'b1);
    u_rem.send(8'h93, 1'b1);
    rdc(`UFF_A_LSTA, 32'h60);
    wr(`UFF_A_DATA, 32'h77);
    repeat (300) @(posedge pclk);
    chk(u_rem.got_q.size(), 32'h0);
    u_rem.send(8'h11, 1'b1);
    u_rem.send(8'h91, 1'b1);
    waitls(8'h40);
    qchk(8'h77);
    $display("test double character done");
    wr(`UFF_A_XOFF2, 32'h1a);
    wr(`UFF_A_ENH, 32'h20);
    u_rem.send(8'h1a, 1'b1);
    rdc(`UFF_A_ISTA, 32'h10);
    rdc(`UFF_A_DATA, 32'h1a);
    $display("test special character done");
    wr(`UFF_A_ENH, 32'h04);
    wr(`UFF_A_XOFF1, 32'h13);
    wr(`UFF_A_XON1, 32'h11);
    for (int k = 0; k < 4; k++) begin
      wr(`UFF_A_ISTA, {24'h0, 2'(k), 6'h01});
      for (int i = 0; i < tl[k]; i++) u_rem.send(8'(8'h30 + i), 1'b1);
      repeat (200) @(posedge pclk);
      chk(u_rem.got_q.size(), 32'h0);
      repeat (300) @(posedge pclk);
      qchk(8'h13);
      for (int i = 0; i < tl[k]; i++) begin
        rdc(`UFF_A_DATA, 32'h30 + i);
        repeat (200) @(posedge pclk);
        if (tl[k] - i - 1 == rl[k]) qchk(8'h11);
        else chk(u_rem.got_q.size(), 32'h0);
      end
    end
    $display("test auto xoff send done");
    give_verdict();
  end
endmodule

// [uff_channel.sv]
// uff_channel: one serial channel with tx/rx fifos, hardware and software flow control
// assumes: apb master on pclk; rxd and cts_n come from the pins, asynchronous to pclk
//
// Decided for this implementation: the APB register port and the register offsets.
`include "uff_params.svh"

// Behaviour
// - tx fifo takes sixteen host bytes
// - tx holding empty flag when fifo empty
// - tx holding empty raises interrupt when enabled
// - tx empty flag needs fifo and shifter idle
// - start bit checked mid-bit, bits sampled centred
// - rx fifo sixteen entries, byte plus tags
// - host read pops, status shows tags of the head entry
// - rx ready interrupt at trigger level
// - timeout after four words plus twelve bits
// - auto rts needs enable and rts bit
// - rts rising edge sets modem interrupt
// - rts drops at upper, returns at lower
// - auto cts gates the transmitter
// - cts deassertion sets modem interrupt
// - cts stop after current stop bit
// - xoff match halts after current character
// - xoff sets flag, xon resumes, clears
// - reset zeroes characters, matches not stored
// - auto xoff sent two chars after trigger
// - xon sent at release level
// - special character stored, sets flag
// - compares use word length bits only
module uff_channel (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rxd,
  input  wire logic        cts_n,
  output logic             txd,
  output logic             rts_n,
  output logic             irq
);
  uff_pkg::uff_st_t s;
  uff_pkg::uff_st_t n;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       thre;
  logic       tpush;
  logic       tpop;
  logic       rpush;
  logic       rin;
  logic       rpop;
  logic       ev;
  logic       xf;
  logic       xn;
  logic       cgate;
  logic       first;
  logic [2:0] last;
  logic [2:0] tag;
  logic [2:0] tagv;
  logic [4:0] trg;
  logic [4:0] rel;
  logic [7:0] msk;
  logic [7:0] rc;
  logic [7:0] lst;
  logic [7:0] ist;
  logic [9:0] tlim;
  logic [9:0] xlim;

  // ==========================================================
  // helpers
  function automatic logic [7:0] wl_mask(input logic [1:0] wl);
    wl_mask = 8'hff >> (2'd3 - wl);
  endfunction

  function automatic logic [4:0] trig_lvl(input logic [1:0] sel, input logic rls);
    case (sel)
      2'd0:    trig_lvl = rls ? `UFF_REL_0 : `UFF_TRIG_0;
      2'd1:    trig_lvl = rls ? `UFF_REL_1 : `UFF_TRIG_1;
      2'd2:    trig_lvl = rls ? `UFF_REL_2 : `UFF_TRIG_2;
      default: trig_lvl = rls ? `UFF_REL_3 : `UFF_TRIG_3;
    endcase
  endfunction

  // ==========================================================
  // next state
  always_comb begin
    n     = s;
    acc   = psel & penable & s.pready;
    wr    = acc & pwrite;
    rd    = acc & ~pwrite;
    last  = 3'(`UFF_WL_MIN - 1) + {1'b0, s.lctl[`UFF_LC_WL +: 2]};
    msk   = wl_mask(s.lctl[`UFF_LC_WL +: 2]);
    tlim  = 10'((`UFF_TMO_WORDS * (`UFF_WL_MIN + s.lctl[`UFF_LC_WL +: 2]) + `UFF_TMO_BITS) * `UFF_OVS);
    xlim  = 10'(`UFF_XOFF_CHARS * (`UFF_WL_MIN + s.lctl[`UFF_LC_WL +: 2] + `UFF_FRAME_EXTRA) * `UFF_OVS);
    trg   = s.fctl[`UFF_FC_EN] ? trig_lvl(s.fctl[`UFF_FC_TRIG +: 2], 1'b0) : `UFF_TRIG_0;
    rel   = s.fctl[`UFF_FC_EN] ? trig_lvl(s.fctl[`UFF_FC_TRIG +: 2], 1'b1) : `UFF_REL_0;
    thre  = (s.tcnt == 5'd0);
    tag   = (s.rcnt != 5'd0) ? s.rxm[s.rrp][`UFF_TAG_POS +: 3] : 3'd0;
    lst   = {1'b0, thre & (s.tst == uff_pkg::TX_IDLE), thre, tag, s.ovr, s.rcnt != 5'd0};
    ist   = {2'b00, s.stk[1], s.stk[0], s.ien[`UFF_IE_RX] & s.tmo,
             s.ien[`UFF_IE_RX] & (s.rcnt >= trg),
             s.ien[`UFF_IE_TX] & thre, 1'b0};
    ist[0] = ~(|ist[5:1]);
    n.irq = |ist[5:1];
    tpush = 1'b0;
    tpop  = 1'b0;
    rpush = 1'b0;
    rpop  = 1'b0;
    ev    = 1'b0;
    xf    = 1'b0;
    xn    = 1'b0;
    first = (s.fpend == 2'd2) | ~s.enh[`UFF_EH_DBL];
    cgate = s.enh[`UFF_EH_ACTS] & s.cts2;
    rc    = s.rsh >> (2'd3 - s.lctl[`UFF_LC_WL +: 2]);
    tagv  = {~s.rxs2 & (rc == 8'h00), ~s.rxs2, 1'b0};

    // 16x sample clock enable
    n.tick = (s.dcnt == 16'h0000);
    n.dcnt = n.tick ? s.div - 16'h0001 : s.dcnt - 16'h0001;

    // apb slave: answer one cycle after setup
    n.pready  = psel & ~penable;
    n.pslverr = 1'b0;
    if (psel & ~penable) begin
      n.prdata = 32'h0000_0000;
      case (paddr)
        `UFF_A_DATA:  n.prdata = {24'h00_0000, s.rxm[s.rrp][7:0]};
        `UFF_A_IEN:   n.prdata = {24'h00_0000, s.ien};
        `UFF_A_ISTA:  n.prdata = {24'h00_0000, ist};
        `UFF_A_LCTL:  n.prdata = {24'h00_0000, s.lctl};
        `UFF_A_MCTL:  n.prdata = {24'h00_0000, s.mctl};
        `UFF_A_LSTA:  n.prdata = {24'h00_0000, lst};
        `UFF_A_ENH:   n.prdata = {24'h00_0000, s.enh};
        `UFF_A_XON1:  n.prdata = {24'h00_0000, s.xon1};
        `UFF_A_XON2:  n.prdata = {24'h00_0000, s.xon2};
        `UFF_A_XOFF1: n.prdata = {24'h00_0000, s.xoff1};
        `UFF_A_XOFF2: n.prdata = {24'h00_0000, s.xoff2};
        `UFF_A_DIV:   n.prdata = {16'h0000, s.div};
        default:      n.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        `UFF_A_DATA:  tpush = (s.tcnt != `UFF_DEPTH);
        `UFF_A_IEN:   n.ien = pwdata[7:0];
        `UFF_A_ISTA:  n.fctl = pwdata[7:0];
        `UFF_A_LCTL:  n.lctl = pwdata[7:0];
        `UFF_A_MCTL:  n.mctl = pwdata[7:0];
        `UFF_A_ENH:   n.enh = pwdata[7:0];
        `UFF_A_XON1:  n.xon1 = pwdata[7:0];
        `UFF_A_XON2:  n.xon2 = pwdata[7:0];
        `UFF_A_XOFF1: n.xoff1 = pwdata[7:0];
        `UFF_A_XOFF2: n.xoff2 = pwdata[7:0];
        `UFF_A_DIV:   n.div = pwdata[15:0];
        default:      n.div = s.div;
      endcase
    end
    if (rd & (paddr == `UFF_A_DATA)) rpop = (s.rcnt != 5'd0);
    // clears come first so that a same-cycle set wins
    if (rd & (paddr == `UFF_A_ISTA)) n.stk = 2'b00;
    if (rd & (paddr == `UFF_A_LSTA)) n.ovr = 1'b0;

    // receiver
    n.rxs1 = rxd;
    n.rxs2 = s.rxs1;
    n.rxp  = s.rxs2;
    n.cts1 = cts_n;
    n.cts2 = s.cts1;
    n.ctsp = s.cts2;
    if (s.tick & (s.rxst != uff_pkg::RX_IDLE)) n.rph = s.rph + 4'd1;
    case (s.rxst)
      uff_pkg::RX_IDLE: begin
        n.rph = 4'd0;
        if (s.rxp & ~s.rxs2) n.rxst = uff_pkg::RX_START;
      end
      uff_pkg::RX_START: begin
        if (s.tick & (s.rph == 4'(`UFF_HALF - 1))) begin
          n.rph  = 4'd0;
          n.rbit = 3'd0;
          n.rxst = s.rxs2 ? uff_pkg::RX_IDLE : uff_pkg::RX_DATA;
        end
      end
      uff_pkg::RX_DATA: begin
        if (s.tick & (s.rph == 4'(`UFF_OVS - 1))) begin
          n.rsh  = {s.rxs2, s.rsh[7:1]};
          n.rbit = s.rbit + 3'd1;
          if (s.rbit == last) n.rxst = uff_pkg::RX_STOP;
        end
      end
      uff_pkg::RX_STOP: begin
        if (s.tick & (s.rph == 4'(`UFF_OVS - 1))) begin
          ev     = 1'b1;
          n.rxst = uff_pkg::RX_IDLE;
        end
      end
      default: n.rxst = uff_pkg::RX_IDLE;
    endcase

    // flow characters and special character on each received character
    if (ev) begin
      rpush = 1'b1;
      if (s.enh[`UFF_EH_SWRX] & s.rxs2) begin
        xf = s.enh[`UFF_EH_DBL] ? s.xoffh & (rc == (s.xoff2 & msk)) : (rc == (s.xoff1 & msk));
        xn = s.enh[`UFF_EH_DBL] ? s.xonh & (rc == (s.xon2 & msk)) : (rc == (s.xon1 & msk));
        n.xoffh = s.enh[`UFF_EH_DBL] & ~xf & ~xn & (rc == (s.xoff1 & msk));
        n.xonh  = s.enh[`UFF_EH_DBL] & ~xf & ~xn & (rc == (s.xon1 & msk));
        if (xf | xn | n.xoffh | n.xonh) rpush = 1'b0;
        if (xf) begin
          n.halt = 1'b1;
          if (s.ien[`UFF_IE_XOFF]) n.stk[0] = 1'b1;
        end
        if (xn) begin
          n.halt   = 1'b0;
          n.stk[0] = 1'b0;
        end
      end else begin
        n.xoffh = 1'b0;
        n.xonh  = 1'b0;
      end
      if (s.enh[`UFF_EH_SPC] & rpush & (rc == (s.xoff2 & msk))) n.stk[0] = 1'b1;
    end

    // receive fifo
    rin = rpush & (s.rcnt != `UFF_DEPTH);
    if (rpush & ~rin) n.ovr = 1'b1;
    if (rin) begin
      n.rxm[s.rwp] = {tagv, rc};
      n.rwp        = s.rwp + 4'd1;
    end
    if (rpop) n.rrp = s.rrp + 4'd1;
    n.rcnt = s.rcnt + 5'(rin) - 5'(rpop);

    // receive time-out
    if ((s.rcnt == 5'd0) | rpop) begin
      n.tmc = 10'd0;
      n.tmo = 1'b0;
    end else if (rin) begin
      n.tmc = 10'd0;
    end else if (s.tick & ~s.tmo) begin
      n.tmc = s.tmc + 10'd1;
      if (s.tmc == tlim - 10'd1) n.tmo = 1'b1;
    end

    // hardware flow control
    if (s.rcnt >= trg) n.rtsok = 1'b0;
    else if (s.rcnt <= rel) n.rtsok = 1'b1;
    n.rts_n = ~(s.mctl[`UFF_MC_RTS] & (~s.enh[`UFF_EH_ARTS] | s.rtsok));
    if (~s.rts_n & n.rts_n & s.ien[`UFF_IE_RTS] & s.enh[`UFF_EH_IEN]) n.stk[1] = 1'b1;
    if (s.cts2 & ~s.ctsp & s.ien[`UFF_IE_CTS] & s.enh[`UFF_EH_IEN]) n.stk[1] = 1'b1;

    // automatic xoff / xon transmission
    if (~s.enh[`UFF_EH_AXOFF]) begin
      n.xsent = 1'b0;
      n.xdly  = 10'd0;
    end else if (~s.xsent) begin
      if (s.rcnt < trg) begin
        n.xdly = 10'd0;
      end else if (s.tick) begin
        n.xdly = s.xdly + 10'd1;
        if (s.xdly == xlim - 10'd1) begin
          n.xsent = 1'b1;
          n.xdly  = 10'd0;
          n.fsel  = 1'b1;
          n.fpend = s.enh[`UFF_EH_DBL] ? 2'd2 : 2'd1;
        end
      end
    end else if (s.rcnt <= rel) begin
      n.xsent = 1'b0;
      n.fsel  = 1'b0;
      n.fpend = s.enh[`UFF_EH_DBL] ? 2'd2 : 2'd1;
    end

    // transmitter; a new character only starts from idle, so gating waits for the stop bit
    if (s.tick & (s.tst != uff_pkg::TX_IDLE)) n.tph = s.tph + 4'd1;
    case (s.tst)
      uff_pkg::TX_IDLE: begin
        if (s.tick & ~cgate) begin
          if (s.fpend != 2'd0) begin
            n.tsh   = s.fsel ? (first ? s.xoff1 : s.xoff2) : (first ? s.xon1 : s.xon2);
            n.fpend = s.fpend - 2'd1;
            n.tst   = uff_pkg::TX_START;
          end else if ((s.tcnt != 5'd0) & ~(s.enh[`UFF_EH_SWRX] & s.halt)) begin
            n.tsh = s.txm[s.trp];
            tpop  = 1'b1;
            n.tst = uff_pkg::TX_START;
          end
          n.txd = (n.tst == uff_pkg::TX_IDLE);
          n.tph = 4'd0;
        end
      end
      uff_pkg::TX_START: begin
        if (s.tick & (s.tph == 4'(`UFF_OVS - 1))) begin
          n.tst  = uff_pkg::TX_DATA;
          n.tbit = 3'd0;
          n.txd  = s.tsh[0];
        end
      end
      uff_pkg::TX_DATA: begin
        if (s.tick & (s.tph == 4'(`UFF_OVS - 1))) begin
          n.tbit = s.tbit + 3'd1;
          n.tsh  = {1'b1, s.tsh[7:1]};
          n.txd  = s.tsh[1];
          if (s.tbit == last) begin
            n.tst = uff_pkg::TX_STOP;
            n.txd = 1'b1;
          end
        end
      end
      uff_pkg::TX_STOP: begin
        if (s.tick & (s.tph == 4'(`UFF_OVS - 1))) n.tst = uff_pkg::TX_IDLE;
      end
      default: n.tst = uff_pkg::TX_IDLE;
    endcase

    // transmit fifo
    if (tpush) begin
      n.txm[s.twp] = pwdata[7:0];
      n.twp        = s.twp + 4'd1;
    end
    if (tpop) n.trp = s.trp + 4'd1;
    n.tcnt = s.tcnt + 5'(tpush) - 5'(tpop);
  end

  // ==========================================================
  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s       <= '0;
      s.div   <= `UFF_DIV_RST;
      s.tst   <= uff_pkg::TX_IDLE;
      s.rxst  <= uff_pkg::RX_IDLE;
      s.txd   <= 1'b1;
      s.rts_n <= 1'b1;
      s.rtsok <= 1'b1;
      s.rxs1  <= 1'b1;
      s.rxs2  <= 1'b1;
      s.rxp   <= 1'b1;
      s.cts1  <= 1'b1;
      s.cts2  <= 1'b1;
      s.ctsp  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign txd     = s.txd;
  assign rts_n   = s.rts_n;
  assign irq     = s.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_TX_DEPTH: assert property (s.tcnt <= `UFF_DEPTH) else $error("tx fifo count over depth");
  AST_THRE: assert property ((psel && !penable && !pwrite && paddr == `UFF_A_LSTA)
    |=> (prdata[5] == ($past(s.tcnt) == 5'd0))) else $error("tx holding empty flag wrong");
  AST_TEMT: assert property ((psel && !penable && !pwrite && paddr == `UFF_A_LSTA) ##1 prdata[6]
    |-> $past(s.tst) == uff_pkg::TX_IDLE && prdata[5]) else $error("tx empty flag set early");
  AST_TX_IRQ: assert property ((s.ien[1] && s.tcnt == 5'd0) |=> irq) else $error("tx empty irq missing");
  AST_START_REJECT: assert property ((s.rxst == uff_pkg::RX_START && s.tick && s.rph == 4'd7 && s.rxs2)
    |=> s.rxst == uff_pkg::RX_IDLE) else $error("false start accepted");
  AST_RX_DEPTH: assert property (s.rcnt <= `UFF_DEPTH) else $error("rx fifo count over depth");
  AST_TMO_DATA: assert property (s.tmo |-> s.rcnt != 5'd0) else $error("timeout with empty fifo");
  AST_RTS_UP: assert property ((s.enh[6] && s.rcnt >= trg) |=> ##1 rts_n) else $error("rts not dropped");
  AST_CTS_HOLD: assert property ((s.tst == uff_pkg::TX_IDLE && s.enh[7] && s.cts2)
    |=> s.tst == uff_pkg::TX_IDLE) else $error("tx started while cts high");
  AST_XOFF_HALT: assert property ((s.halt && s.enh[0] && s.fpend == 2'd0 && s.tst == uff_pkg::TX_IDLE)
    |=> s.tst == uff_pkg::TX_IDLE) else $error("tx started while halted");

  COV_TX_CHAR: cover property (s.tst == uff_pkg::TX_STOP ##1 s.tst == uff_pkg::TX_IDLE);
  COV_RX_PUSH: cover property (rin);
  COV_XOFF: cover property (!s.halt ##1 s.halt);
  COV_RTS_RISE: cover property (!rts_n ##1 rts_n);
endmodule

// [uff_params.svh]
// uff_params.svh: offsets, field positions, reset values and counts of the serial channel
// assumes: included by uff_pkg and uff_channel; no process lives here
`ifndef UFF_PARAMS_SVH
`define UFF_PARAMS_SVH
// ==========================================================
// register byte offsets
`define UFF_A_DATA  8'h00
`define UFF_A_IEN   8'h04
`define UFF_A_ISTA  8'h08
`define UFF_A_LCTL  8'h0c
`define UFF_A_MCTL  8'h10
`define UFF_A_LSTA  8'h14
`define UFF_A_ENH   8'h18
`define UFF_A_XON1  8'h1c
`define UFF_A_XON2  8'h20
`define UFF_A_XOFF1 8'h24
`define UFF_A_XOFF2 8'h28
`define UFF_A_DIV   8'h2c
// ==========================================================
// field positions
`define UFF_IE_RX    0
`define UFF_IE_TX    1
`define UFF_IE_XOFF  5
`define UFF_IE_RTS   6
`define UFF_IE_CTS   7
`define UFF_MC_RTS   1
`define UFF_FC_EN    0
`define UFF_FC_TRIG  6
`define UFF_LC_WL    0
`define UFF_EH_SWRX  0
`define UFF_EH_DBL   1
`define UFF_EH_AXOFF 2
`define UFF_EH_IEN   4
`define UFF_EH_SPC   5
`define UFF_EH_ARTS  6
`define UFF_EH_ACTS  7
`define UFF_TAG_POS  8
// ==========================================================
// sizes, counts and reset values
`define UFF_DEPTH    5'd16
`define UFF_RXW      11
`define UFF_OVS      16
`define UFF_HALF     8
`define UFF_WL_MIN   5
`define UFF_TMO_WORDS 4
`define UFF_TMO_BITS 12
`define UFF_XOFF_CHARS 2
`define UFF_FRAME_EXTRA 2
`define UFF_DIV_RST  16'h0001
`define UFF_TRIG_0   5'd1
`define UFF_TRIG_1   5'd4
`define UFF_TRIG_2   5'd8
`define UFF_TRIG_3   5'd14
`define UFF_REL_0    5'd0
`define UFF_REL_1    5'd1
`define UFF_REL_2    5'd4
`define UFF_REL_3    5'd8
`endif

// [uff_pkg.sv]
// uff_pkg: state types of the serial channel
// assumes: uff_params.svh is on the include path
`include "uff_params.svh"
package uff_pkg;
  // ==========================================================
  // state machines
  typedef enum logic [3:0] {
    TX_IDLE  = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA  = 4'b0100,
    TX_STOP  = 4'b1000
  } uff_tx_t;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'b0001,
    RX_START = 4'b0010,
    RX_DATA  = 4'b0100,
    RX_STOP  = 4'b1000
  } uff_rx_t;
  // ==========================================================
  // whole state of the channel
  typedef struct packed {
    logic [7:0]                        ien, lctl, mctl, fctl, enh, xon1, xon2, xoff1, xoff2;
    logic [15:0]                       div, dcnt;
    logic                              tick;
    logic [`UFF_DEPTH-1:0][7:0]        txm;
    logic [`UFF_DEPTH-1:0][`UFF_RXW-1:0] rxm;
    logic [3:0]                        twp, trp, rwp, rrp, tph, rph;
    logic [4:0]                        tcnt, rcnt;
    uff_tx_t                           tst;
    uff_rx_t                           rxst;
    logic [7:0]                        tsh, rsh;
    logic [2:0]                        tbit, rbit;
    logic                              ovr, tmo, rtsok, halt, xoffh, xonh, xsent, fsel;
    logic [9:0]                        tmc, xdly;
    logic [1:0]                        stk, fpend;
    logic                              rxs1, rxs2, rxp, cts1, cts2, ctsp;
    logic                              txd, rts_n, irq, pready, pslverr;
    logic [31:0]                       prdata;
  } uff_st_t;
endpackage

// [uff_remote.sv]
// uff_remote.sv: behavioural far-end serial partner of the channel
// assumes: divisor 1, so one bit is 16 pclk cycles; the bench calls its tasks by hierarchy
module uff_remote (
  input  wire logic pclk,
  input  wire logic txd,
  output logic      rxd,
  output logic      cts_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int         nbits;
  logic [7:0] got_q[$];
  logic [7:0] v;
  initial begin
    rxd   = 1'b1;
    cts_n = 1'b0;
    nbits = 8;
  end
  // ==========================================================
  // transmit side, drives the channel receiver
  task automatic bit_out(input logic b);
    rxd <= b;
    repeat (16) @(posedge pclk);
  endtask
  task automatic send(input logic [7:0] d, input logic stop);
    @(posedge pclk);
    bit_out(1'b0);
    for (int i = 0; i < nbits; i++) bit_out(d[i]);
    bit_out(stop);
    if (!stop) bit_out(1'b1);
    rxd <= 1'b1;
  endtask
  // short low pulse that must not pass the mid-bit check
  task automatic glitch();
    @(posedge pclk);
    rxd <= 1'b0;
    repeat (4) @(posedge pclk);
    rxd <= 1'b1;
  endtask
  task automatic set_cts(input logic x);
    @(posedge pclk);
    cts_n <= x;
  endtask
  // ==========================================================
  // receive side, decodes the channel transmitter mid-bit
  initial forever begin
    @(negedge pclk);
    if (txd === 1'b0) begin
      v = 8'h00;
      repeat (8) @(negedge pclk);
      for (int i = 0; i < nbits; i++) begin
        repeat (16) @(negedge pclk);
        v[i] = txd;
      end
      repeat (16) @(negedge pclk);
      got_q.push_back(v);
    end
  end
endmodule
